//--- fpo_ctrl.sv
// Fuse option programmer: AHB-Lite registers and pulse sequencer
//
// Functional notes
// - Term number goes out as a binary code on the six function outputs.
// - One fuse link per pulse; address never changes during a pulse.
// - Data inputs raised to programming level, nominal supply, before each pulse.
// - Supply steps nominal to program level, back to nominal after the pulse.
// - Pulse length lies between minimum and maximum; nominal length used.
// - Off time between pulses keeps duty cycle at nominal, below the limit.
// - Data inputs return to logic levels only after recovery interval.
// - Polarity fuse is checked first and skipped if already programmed.
// - Shared input as twelfth data input needs term 56 fused.
// - Shared input as enable keeps term 56 intact, both links blown everywhere.
// - Polarity fuses are blown only after enables and both matrices; the start guard checks only the mdone bit, not the enables.
// - Continuous enable term may be fused early to ease verification.
// - Supply removed between pulses to limit heating.
// - Product terms are programmed before the matching summing entries.
`timescale 1ns/1ps
module fpo_ctrl #(
    parameter int unsigned PULSE_CYC = fpo_pkg::PULSE_CYC,
    parameter int unsigned COOL_CYC  = fpo_pkg::COOL_CYC
) (
    // Clock and reset
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    // AHB-Lite slave
    input  wire logic        hsel_i,
    input  wire logic [31:0] haddr_i,
    input  wire logic [1:0]  htrans_i,
    input  wire logic        hwrite_i,
    input  wire logic [2:0]  hsize_i,
    input  wire logic [31:0] hwdata_i,
    input  wire logic        hready_i,
    output logic             hreadyout_o,
    output logic             hresp_o,
    output logic [31:0]      hrdata_o,
    // Device supply and data inputs
    output logic             supply_on_o,
    output logic             supply_prog_o,
    output logic             data_raise_o,
    output logic [11:0]      data_o,
    // Function output pins
    input  wire logic [5:0]  func_out_i,
    output logic [5:0]       func_out_o,
    output logic [5:0]       func_oe_o
);

    localparam int CW = fpo_pkg::CNT_W;

    typedef struct packed {
        fpo_pkg::fpo_state_e st;
        logic [5:0]          term;
        logic [11:0]         vpat;
        logic                mdone;
        logic                done;
        logic                skip;
        logic                err;
        logic                chk_ok;
        logic                wr_pend;
        logic [7:0]          wr_addr;
        logic [31:0]         hrdata;
        logic                hready;
        logic                sup_on;
        logic                sup_prog;
        logic                raise;
        logic [11:0]         data;
        logic [5:0]          fout;
        logic [5:0]          foe;
        logic                seen;
        logic [CW-1:0]       plen;
        logic [CW-1:0]       gap;
        logic [7:0]          rgap;
    } fpo_ctl_s;

    fpo_ctl_s         s_q;
    fpo_ctl_s         s_d;
    logic             tmr_ld;
    logic [CW-1:0]    tmr_val;
    logic             tmr_done;
    logic [5:0]       fsync;
    logic             start;
    logic             is_pol;
    logic             bad_term;
    logic             clr_done;
    logic             clr_skip;
    logic             clr_err;

    // ------------------------------------------------------------
    // Submodules
    // ------------------------------------------------------------
    fpo_sync3 #(.W(6)) u_sync (
        .clk_i (clk_i),
        .rst_i (rst_i),
        .d_i   (func_out_i),
        .q_o   (fsync)
    );

    fpo_timer #(.W(CW)) u_tmr (
        .clk_i  (clk_i),
        .rst_i  (rst_i),
        .load_i (tmr_ld),
        .val_i  (tmr_val),
        .done_o (tmr_done)
    );

    // ------------------------------------------------------------
    // Register access and sequencer
    // ------------------------------------------------------------
    always_comb
    begin
        s_d      = s_q;
        tmr_ld   = 1'b0;
        tmr_val  = '0;
        start    = 1'b0;
        clr_done = 1'b0;
        clr_skip = 1'b0;
        clr_err  = 1'b0;
        is_pol   = (s_q.term >= fpo_pkg::TERM_POL_FIRST) && (s_q.term <= fpo_pkg::TERM_POL_LAST);
        // Only option and polarity terms belong here; terms 56 and 57 are
        // always allowed, so fusing 56 early needs no ordering guard
        bad_term = (s_q.term < fpo_pkg::TERM_POL_FIRST) || (s_q.term > fpo_pkg::TERM_AUTO_EN);

        // Data phase of a write; writes land with zero wait states
        s_d.wr_pend = 1'b0;
        if (s_q.wr_pend)
        begin
            case (s_q.wr_addr)
                fpo_pkg::OFS_CTRL:
                begin
                    s_d.mdone = hwdata_i[fpo_pkg::CTRL_MDONE];
                    start     = hwdata_i[fpo_pkg::CTRL_START];
                end
                fpo_pkg::OFS_TERM:
                begin
                    // Term is frozen while a sequence runs
                    if (s_q.st == fpo_pkg::ST_IDLE)
                    begin
                        s_d.term = hwdata_i[5:0];
                    end
                end
                fpo_pkg::OFS_VPAT:
                begin
                    s_d.vpat = hwdata_i[11:0];
                end
                fpo_pkg::OFS_STAT:
                begin
                    clr_done = hwdata_i[fpo_pkg::STAT_DONE];
                    clr_skip = hwdata_i[fpo_pkg::STAT_SKIP];
                    clr_err  = hwdata_i[fpo_pkg::STAT_ERR];
                end
                default:
                begin
                    s_d.wr_pend = 1'b0;
                end
            endcase
        end
        if (clr_done) s_d.done = 1'b0;
        if (clr_skip) s_d.skip = 1'b0;
        if (clr_err)  s_d.err  = 1'b0;

        // Address phase
        s_d.hready = 1'b1;
        if (hsel_i && htrans_i[1] && hready_i)
        begin
            s_d.wr_pend = hwrite_i;
            s_d.wr_addr = {haddr_i[7:2], 2'b00};
            s_d.hrdata  = '0;
            if (!hwrite_i)
            begin
                case ({haddr_i[7:2], 2'b00})
                    fpo_pkg::OFS_CTRL: s_d.hrdata[fpo_pkg::CTRL_MDONE] = s_q.mdone;
                    fpo_pkg::OFS_TERM: s_d.hrdata[5:0] = s_q.term;
                    fpo_pkg::OFS_VPAT: s_d.hrdata[11:0] = s_q.vpat;
                    fpo_pkg::OFS_STAT:
                    begin
                        s_d.hrdata[fpo_pkg::STAT_BUSY] = (s_q.st != fpo_pkg::ST_IDLE);
                        s_d.hrdata[fpo_pkg::STAT_DONE] = s_q.done;
                        s_d.hrdata[fpo_pkg::STAT_SKIP] = s_q.skip;
                        s_d.hrdata[fpo_pkg::STAT_ERR]  = s_q.err;
                        s_d.hrdata[fpo_pkg::STAT_ST_LSB +: 3] = s_q.st;
                    end
                    fpo_pkg::OFS_SAMP: s_d.hrdata[5:0] = fsync;
                    default:           s_d.hrdata = '0;
                endcase
            end
        end

        case (s_q.st)
            fpo_pkg::ST_IDLE:
            begin
                if (start)
                begin
                    // The mdone bit written with start counts, not the old one
                    if (bad_term || (is_pol && !s_d.mdone))
                    begin
                        s_d.err = 1'b1;
                    end
                    else
                    begin
                        s_d.sup_on = 1'b1;
                        s_d.chk_ok = !is_pol;
                        tmr_ld     = 1'b1;
                        tmr_val    = CW'(fpo_pkg::SETTLE_CYC - 1);
                        if (is_pol)
                        begin
                            // Logic levels applied so the output can be read back
                            s_d.data = s_q.vpat;
                            s_d.st   = fpo_pkg::ST_VSET;
                        end
                        else
                        begin
                            s_d.raise = 1'b1;
                            s_d.fout  = s_q.term;
                            s_d.foe   = 6'h3F;
                            s_d.st    = fpo_pkg::ST_RAISE;
                        end
                    end
                end
            end
            fpo_pkg::ST_VSET:
            begin
                if (tmr_done)
                begin
                    // Term 50 maps to output five, term 55 to output zero
                    if (!fsync[3'h7 - s_q.term[2:0]])
                    begin
                        s_d.skip   = 1'b1;
                        s_d.done   = 1'b1;
                        s_d.sup_on = 1'b0;
                        s_d.st     = fpo_pkg::ST_IDLE;
                    end
                    else
                    begin
                        s_d.chk_ok = 1'b1;
                        s_d.raise  = 1'b1;
                        s_d.fout   = s_q.term;
                        s_d.foe    = 6'h3F;
                        tmr_ld     = 1'b1;
                        tmr_val    = CW'(fpo_pkg::SETTLE_CYC - 1);
                        s_d.st     = fpo_pkg::ST_RAISE;
                    end
                end
            end
            fpo_pkg::ST_RAISE:
            begin
                if (tmr_done)
                begin
                    s_d.sup_prog = 1'b1;
                    tmr_ld       = 1'b1;
                    tmr_val      = CW'(PULSE_CYC - 1);
                    s_d.st       = fpo_pkg::ST_PULSE;
                end
            end
            fpo_pkg::ST_PULSE:
            begin
                if (tmr_done)
                begin
                    s_d.sup_prog = 1'b0;
                    tmr_ld       = 1'b1;
                    tmr_val      = CW'(fpo_pkg::RECOV_CYC - 1);
                    s_d.st       = fpo_pkg::ST_RECOV;
                end
            end
            fpo_pkg::ST_RECOV:
            begin
                if (tmr_done)
                begin
                    s_d.raise  = 1'b0;
                    s_d.data   = s_q.vpat;
                    s_d.foe    = 6'h00;
                    s_d.sup_on = 1'b0;
                    tmr_ld     = 1'b1;
                    tmr_val    = CW'(COOL_CYC - 1);
                    s_d.st     = fpo_pkg::ST_COOL;
                end
            end
            fpo_pkg::ST_COOL:
            begin
                // Busy until the off time ends, so software cannot beat the duty limit
                if (tmr_done)
                begin
                    s_d.done = 1'b1;
                    s_d.st   = fpo_pkg::ST_IDLE;
                end
            end
            default:
            begin
                s_d.st = fpo_pkg::ST_IDLE;
            end
        endcase

        // Observation counters for pulse length and spacing
        s_d.plen = s_q.sup_prog ? s_q.plen + CW'(1) : '0;
        s_d.gap  = s_q.sup_prog ? '0 : ((&s_q.gap) ? s_q.gap : s_q.gap + CW'(1));
        s_d.rgap = s_q.sup_prog ? '0 : ((&s_q.rgap) ? s_q.rgap : s_q.rgap + 8'h01);
        s_d.seen = s_q.seen | s_q.sup_prog;
    end

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            s_q      <= '0;
            s_q.term <= fpo_pkg::TERM_RST;
            s_q.vpat <= fpo_pkg::VPAT_RST;
        end
        else
        begin
            s_q <= s_d;
        end
    end

    assign hreadyout_o   = s_q.hready;
    assign hresp_o       = 1'b0;
    assign hrdata_o      = s_q.hrdata;
    assign supply_on_o   = s_q.sup_on;
    assign supply_prog_o = s_q.sup_prog;
    assign data_raise_o  = s_q.raise;
    assign data_o        = s_q.data;
    assign func_out_o    = s_q.fout;
    assign func_oe_o     = s_q.foe;

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    sequence s_pulse_start;
        $rose(supply_prog_o);
    endsequence

    sequence s_pulse_end;
        $fell(supply_prog_o);
    endsequence

    a_term_code: assert property (@(posedge clk_i) disable iff (rst_i)
        supply_prog_o |-> (func_oe_o == 6'h3F) && (func_out_o == s_q.term))
        else $error("term code not on function outputs during pulse");

    a_addr_stable: assert property (@(posedge clk_i) disable iff (rst_i)
        supply_prog_o && $past(supply_prog_o) |-> $stable(func_out_o))
        else $error("fuse address changed inside a pulse");

    a_raised_data: assert property (@(posedge clk_i) disable iff (rst_i)
        s_pulse_start |-> data_raise_o && $past(data_raise_o, 2) && supply_on_o)
        else $error("pulse without raised data inputs");

    a_back_nominal: assert property (@(posedge clk_i) disable iff (rst_i)
        s_pulse_end |-> supply_on_o ##1 supply_on_o)
        else $error("supply not back at nominal after pulse");

    a_pulse_len: assert property (@(posedge clk_i) disable iff (rst_i)
        s_pulse_end |-> (s_q.plen == CW'(PULSE_CYC)))
        else $error("pulse length wrong");

    a_duty_gap: assert property (@(posedge clk_i) disable iff (rst_i)
        s_pulse_start |-> !s_q.seen || (s_q.gap >= CW'(COOL_CYC)))
        else $error("pulses too close for duty cycle");

    a_recov_wait: assert property (@(posedge clk_i) disable iff (rst_i)
        $fell(data_raise_o) |-> s_q.rgap >= 8'(fpo_pkg::RECOV_CYC))
        else $error("data inputs lowered too soon");

    a_polar_check: assert property (@(posedge clk_i) disable iff (rst_i)
        s_pulse_start |-> s_q.chk_ok)
        else $error("polarity pulse without readback check");

    a_order_guard: assert property (@(posedge clk_i) disable iff (rst_i)
        s_pulse_start and is_pol |-> s_q.mdone)
        else $error("polarity fuse before matrices done");

    a_supply_off: assert property (@(posedge clk_i) disable iff (rst_i)
        (s_q.st == fpo_pkg::ST_COOL) |-> !supply_on_o && !supply_prog_o)
        else $error("supply left on between pulses");

endmodule

//--- fpo_dev_model.sv
// Behavioural model of the fuse-programmed logic array seen by the programmer
`timescale 1ns/1ps
module fpo_dev_model #(
    parameter int unsigned MIN_CYC = 1
) (
    // Clock and reset
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    // Supply and data inputs
    input  wire logic        supply_on_i,
    input  wire logic        supply_prog_i,
    input  wire logic        data_raise_i,
    input  wire logic [11:0] data_i,
    // Function output pins
    input  wire logic [5:0]  drv_i,
    input  wire logic [5:0]  oe_i,
    output logic      [5:0]  pin_o,
    // Observation
    output logic      [7:0]  fuse_o,
    output int               viol_o,
    output int               npulse_o,
    output int               last_o
);
    int         plen;
    int         gap;
    int         v;
    logic       prog_q;
    logic       raise_q;
    logic       off_seen;
    logic [5:0] code_q;
    logic       term_true;
    logic       en;

    // Any nonzero input pattern is taken as a true product term
    assign term_true = |data_i;
    assign en        = fuse_o[7] ? term_true : 1'b1;

    always_comb
    begin
        for (int b = 0; b < 6; b++)
        begin
            if (oe_i[b])
                pin_o[b] = drv_i[b];
            else if (!supply_on_i || data_raise_i || !en)
                pin_o[b] = 1'b1; // Pull-up variant, disabled outputs read high
            else
                pin_o[b] = term_true ^ fuse_o[5 - b];
        end
    end

    always @(posedge clk_i)
    begin
        v = 0;
        if (rst_i)
        begin
            fuse_o   <= 8'h00;
            viol_o   <= 0;
            npulse_o <= 0;
            last_o   <= 0;
            plen     <= 0;
            gap      <= 1000000;
            off_seen <= 1'b1;
        end
        else
        begin
            if (!supply_on_i)
                off_seen <= 1'b1;
            if (supply_prog_i)
            begin
                plen <= plen + 1;
                gap  <= 0;
                if (!supply_on_i || !data_raise_i || oe_i !== 6'h3F)
                    v++;
                if (prog_q && drv_i !== code_q)
                    v++;
                if (!prog_q)
                begin
                    code_q   <= drv_i;
                    off_seen <= 1'b0;
                    if (!off_seen || gap * 35 < last_o * 65)
                        v++;
                end
            end
            else
            begin
                plen <= 0;
                gap  <= gap + 1;
            end
            if (prog_q && !supply_prog_i)
            begin
                npulse_o <= npulse_o + 1;
                last_o   <= plen;
                if (plen >= MIN_CYC && code_q >= 6'h32 && code_q <= 6'h39)
                    fuse_o[code_q - 6'h32] <= 1'b1;
                else
                    v++;
            end
            if (raise_q && !data_raise_i && gap < fpo_pkg::RECOV_CYC)
                v++;
            viol_o <= viol_o + v;
        end
        prog_q  <= supply_prog_i;
        raise_q <= data_raise_i;
    end
endmodule

//--- fpo_pkg.sv
// Shared constants and types of the fuse option programmer
package fpo_pkg;

    // ------------------------------------------------------------
    // Clock and timing
    // ------------------------------------------------------------
    localparam int unsigned CLK_PERIOD_NS  = 5;
    localparam int unsigned PULSE_MIN_NS   = 98000;
    localparam int unsigned PULSE_NOM_NS   = 100000;
    localparam int unsigned PULSE_MAX_NS   = 1000000;
    localparam int unsigned DUTY_NOM_PCT   = 25;
    localparam int unsigned DUTY_MAX_PCT   = 35;
    localparam int unsigned RECOV_NS       = 1000;
    localparam int unsigned SETTLE_NS      = 1000;
    localparam int unsigned PULSE_CYC      = PULSE_NOM_NS / CLK_PERIOD_NS;
    localparam int unsigned PULSE_MIN_CYC  = (PULSE_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int unsigned PULSE_MAX_CYC  = PULSE_MAX_NS / CLK_PERIOD_NS;
    localparam int unsigned COOL_CYC       = PULSE_CYC * (100 - DUTY_NOM_PCT) / DUTY_NOM_PCT;
    localparam int unsigned RECOV_CYC      = (RECOV_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int unsigned SETTLE_CYC     = (SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int unsigned CNT_W          = 17;

    // ------------------------------------------------------------
    // Term codes placed on the function outputs
    // ------------------------------------------------------------
    localparam logic [5:0] TERM_POL_FIRST  = 6'h32;
    localparam logic [5:0] TERM_POL_LAST   = 6'h37;
    localparam logic [5:0] TERM_CONT_EN    = 6'h38;
    localparam logic [5:0] TERM_AUTO_EN    = 6'h39;

    // ------------------------------------------------------------
    // Register map (byte offsets) and fields
    // ------------------------------------------------------------
    localparam logic [7:0] OFS_CTRL        = 8'h00;
    localparam logic [7:0] OFS_TERM        = 8'h04;
    localparam logic [7:0] OFS_VPAT        = 8'h08;
    localparam logic [7:0] OFS_STAT        = 8'h0C;
    localparam logic [7:0] OFS_SAMP        = 8'h10;
    localparam int unsigned CTRL_START     = 0;
    localparam int unsigned CTRL_MDONE     = 1;
    localparam int unsigned STAT_BUSY      = 0;
    localparam int unsigned STAT_DONE      = 1;
    localparam int unsigned STAT_SKIP      = 2;
    localparam int unsigned STAT_ERR       = 3;
    localparam int unsigned STAT_ST_LSB    = 4;
    localparam logic [11:0] VPAT_RST       = 12'h000;
    localparam logic [5:0]  TERM_RST       = 6'h39;

    typedef enum logic [2:0] {
        ST_IDLE  = 3'b000,
        ST_VSET  = 3'b001,
        ST_RAISE = 3'b010,
        ST_PULSE = 3'b011,
        ST_RECOV = 3'b100,
        ST_COOL  = 3'b101
    } fpo_state_e;

endpackage

//--- fpo_sync3.sv
// Three-stage input synchroniser with agreement filter
`timescale 1ns/1ps
module fpo_sync3 #(
    parameter int W = 6
) (
    // Clock and reset
    input  wire logic         clk_i,
    input  wire logic         rst_i,
    // Data
    input  wire logic [W-1:0] d_i,
    output logic      [W-1:0] q_o
);

    typedef struct packed {
        logic [W-1:0] s1;
        logic [W-1:0] s2;
        logic [W-1:0] s3;
        logic [W-1:0] val;
    } fpo_sync_s;

    fpo_sync_s s_q;
    fpo_sync_s s_d;

    always_comb
    begin
        s_d    = s_q;
        s_d.s1 = d_i;
        s_d.s2 = s_q.s1;
        s_d.s3 = s_q.s2;
        // Only the two later stages are compared, never the first
        for (int i = 0; i < W; i++)
        begin
            if (s_q.s2[i] == s_q.s3[i])
            begin
                s_d.val[i] = s_q.s3[i];
            end
        end
    end

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            s_q <= '0;
        end
        else
        begin
            s_q <= s_d;
        end
    end

    assign q_o = s_q.val;

endmodule

//--- fpo_timer.sv
// Loadable down counter used for every sequence interval
`timescale 1ns/1ps
module fpo_timer #(
    parameter int W = 17
) (
    // Clock and reset
    input  wire logic         clk_i,
    input  wire logic         rst_i,
    // Control
    input  wire logic         load_i,
    input  wire logic [W-1:0] val_i,
    output logic              done_o
);

    typedef struct packed {
        logic [W-1:0] cnt;
    } fpo_tmr_s;

    fpo_tmr_s s_q;
    fpo_tmr_s s_d;

    always_comb
    begin
        s_d = s_q;
        if (load_i)
        begin
            s_d.cnt = val_i;
        end
        else if (s_q.cnt != '0)
        begin
            s_d.cnt = s_q.cnt - W'(1);
        end
    end

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            s_q <= '0;
        end
        else
        begin
            s_q <= s_d;
        end
    end

    assign done_o = (s_q.cnt == '0);

endmodule

//--- tb_top.sv
// Self-checking testbench of the fuse option programmer
`timescale 1ns/1ps
module tb_top;
    localparam int unsigned PCYC = 50;
    localparam int unsigned CCYC = 150;
    logic        clk_i = 1'b0;
    logic        rst_i = 1'b1;
    logic        hsel = 1'b0;
    logic [31:0] haddr = 32'h0;
    logic [1:0]  htrans = 2'b00;
    logic        hwrite = 1'b0;
    logic [31:0] hwdata = 32'h0;
    logic        hready;
    logic        hresp;
    logic [31:0] hrdata;
    logic        s_on, s_prog, raise;
    logic [11:0] data;
    logic [5:0]  pin, drv, oe;
    logic [7:0]  fuse;
    int          viol, npulse, last;
    int          mismatches = 0;
    int          compares = 0;

    always #2.5 clk_i = ~clk_i;

    fpo_ctrl #(.PULSE_CYC(PCYC), .COOL_CYC(CCYC)) i_dut (
        .clk_i(clk_i), .rst_i(rst_i), .hsel_i(hsel), .haddr_i(haddr),
        .htrans_i(htrans), .hwrite_i(hwrite), .hsize_i(3'h2), .hwdata_i(hwdata),
        .hready_i(hready), .hreadyout_o(hready), .hresp_o(hresp), .hrdata_o(hrdata),
        .supply_on_o(s_on), .supply_prog_o(s_prog), .data_raise_o(raise),
        .data_o(data), .func_out_i(pin), .func_out_o(drv), .func_oe_o(oe));

    fpo_dev_model #(.MIN_CYC(PCYC)) i_dev (
        .clk_i(clk_i), .rst_i(rst_i), .supply_on_i(s_on), .supply_prog_i(s_prog),
        .data_raise_i(raise), .data_i(data), .drv_i(drv), .oe_i(oe), .pin_o(pin),
        .fuse_o(fuse), .viol_o(viol), .npulse_o(npulse), .last_o(last));

    task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
        compares++;
        if (s !== e)
        begin
            mismatches++;
            $display("[FAIL] %s expected %h seen %h", n, e, s);
        end
    endtask

    task automatic print_verdict;
        if (mismatches == 0 && compares > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask

    // Single AHB-Lite transfer; address held until hready is seen high
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d,
                       output logic [31:0] q);
        @(posedge clk_i);
        hsel   <= 1'b1;
        haddr  <= {24'h000000, a};
        htrans <= 2'b10;
        hwrite <= w;
        do @(posedge clk_i); while (hready !== 1'b1);
        htrans <= 2'b00;
        hwdata <= d;
        do @(posedge clk_i); while (hready !== 1'b1);
        q = hrdata;
        hsel <= 1'b0;
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] q;
        bus(1'b1, a, d, q);
    endtask

    task automatic rd(input string n, input logic [7:0] a, input logic [31:0] e);
        logic [31:0] q;
        bus(1'b0, a, 32'h0, q);
        chk(n, q, e);
    endtask

    // Clears sticky flags, starts one term and polls until a flag appears
    task automatic run(input logic [5:0] t, input logic md);
        logic [31:0] q;
        int          n;
        wr(fpo_pkg::OFS_STAT, 32'h0000000E);
        wr(fpo_pkg::OFS_TERM, {26'h0, t});
        wr(fpo_pkg::OFS_CTRL, {30'h0, md, 1'b1});
        n = 0;
        q = 32'h0;
        while (q[3:1] === 3'b000 && n < 2000)
        begin
            bus(1'b0, fpo_pkg::OFS_STAT, 32'h0, q);
            n++;
        end
    endtask

    initial
    begin
        repeat (40000) @(posedge clk_i);
        mismatches++;
        print_verdict();
    end

    initial
    begin
        repeat (3) @(posedge clk_i);
        rst_i <= 1'b0;
        rd("term reset", fpo_pkg::OFS_TERM, 32'h00000039);
        rd("stat reset", fpo_pkg::OFS_STAT, 32'h00000000);
        rd("unmapped", 8'h14, 32'h00000000);
        rd("pins unpowered", fpo_pkg::OFS_SAMP, 32'h0000003F);
        chk("fuses new", {24'h0, fuse}, 32'h00000000);
        wr(fpo_pkg::OFS_VPAT, 32'h00000A5C);
        rd("vpat", fpo_pkg::OFS_VPAT, 32'h00000A5C);
        // ------------------------------------------------------------
        // Refused starts: product term code and polarity without mdone
        // ------------------------------------------------------------
        run(6'h31, 1'b1);
        rd("stat bad term", fpo_pkg::OFS_STAT, 32'h00000008);
        run(6'h32, 1'b0);
        rd("stat no mdone", fpo_pkg::OFS_STAT, 32'h00000008);
        chk("no pulse", npulse, 32'd0);
        // ------------------------------------------------------------
        // Enable options, then every polarity term
        // ------------------------------------------------------------
        run(6'h38, 1'b0);
        rd("stat t56", fpo_pkg::OFS_STAT, 32'h00000002);
        chk("fuse t56", {24'h0, fuse}, 32'h00000040);
        chk("pulse len", last, PCYC);
        run(6'h39, 1'b0);
        chk("fuse t57", {24'h0, fuse}, 32'h000000C0);
        for (int t = 50; t < 56; t++)
        begin
            run(t[5:0], 1'b1);
            rd("stat pol", fpo_pkg::OFS_STAT, 32'h00000002);
        end
        chk("fuse all", {24'h0, fuse}, 32'h000000FF);
        run(6'h32, 1'b1);
        rd("stat skip", fpo_pkg::OFS_STAT, 32'h00000006);
        chk("pulses", npulse, 32'd8);
        chk("viol", viol, 32'd0);
        print_verdict();
    end
endmodule
